// ---- hw/odtzq_top.sv ----
// termination timing around frozen-DLL power-down, plus calibration
`timescale 1ns/1ps

module odtzq_top (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // command pins, registered on clk
  input wire logic cke,
  input wire logic odt,
  input wire logic cmd_ref,
  input wire logic cmd_zqcl,
  input wire logic cmd_zqcs,
  // mode settings
  input wire logic pd_dll_fast,
  input wire logic [3:0] wl,
  input wire logic [3:0] al,
  // termination state
  output logic rtt_on,
  output logic async_mode,
  output logic odt_trans,
  // calibration state
  output logic zq_busy,
  output logic zq_cur_en,
  output logic zq_load
);

  odtzq_pkg::odtzq_st_t st_r;
  odtzq_pkg::odtzq_st_t st_nxt;
  logic [4:0] sync_lat;
  logic [4:0] tap;
  logic cke_fall;
  logic cke_rise;
  logic trans;

  odtzq_zq_if zq ();

  ////////////////////////////////////////////////////////////////////////
  // calibration engine

  // only explicit commands start it; self-refresh exit starts nothing
  assign zq.start_long = cmd_zqcl;
  assign zq.start_short = cmd_zqcs;

  odtzq_zq_engine u_zq (
    .clk(clk),
    .arst_n(arst_n),
    .zq(zq.eng)
  );

  assign zq_busy = zq.busy;
  assign zq_cur_en = zq.cur_en;
  assign zq_load = zq.load;

  ////////////////////////////////////////////////////////////////////////
  // synchronous latency and pipeline tap

  always_comb begin
    sync_lat = {1'b0, wl} + {1'b0, al};
    if (sync_lat <= odtzq_pkg::SYNC_OFS) begin
      sync_lat = odtzq_pkg::LAT_MIN;
    end else begin
      sync_lat = sync_lat - odtzq_pkg::SYNC_OFS;
    end
    tap = sync_lat - 5'h01;
  end

  assign cke_fall = st_r.cke_q & ~cke;
  assign cke_rise = ~st_r.cke_q & cke;
  // windows run off counters, so overlapping windows simply merge
  assign trans = (st_r.ent_cnt != '0) || st_r.ent_ref ||
                 (st_r.ex_cnt != '0);

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_nxt = st_r;
    st_nxt.pipe = {st_r.pipe[odtzq_pkg::PIPE_W-2:0], odt};
    st_nxt.cke_q = cke;

    // refresh busy time, tracked for the entry window
    if (cmd_ref) begin
      st_nxt.rfc_cnt = odtzq_pkg::RCNT_W'(odtzq_pkg::RFC_CYC);
    end else if (st_r.rfc_cnt != '0) begin
      st_nxt.rfc_cnt = st_r.rfc_cnt - 1'b1;
    end

    // entry: only when the DLL is frozen in power-down
    if (cke_fall && !pd_dll_fast) begin
      st_nxt.frz = 1'b1;
      st_nxt.ent_cnt = odtzq_pkg::TCNT_W'(odtzq_pkg::CPDED_CYC);
      st_nxt.ent_ref = (st_r.rfc_cnt > 1) || cmd_ref;
    end else begin
      if (st_r.ent_cnt != '0) begin
        st_nxt.ent_cnt = st_r.ent_cnt - 1'b1;
      end
      // refresh end point stays inside the window
      if (st_r.rfc_cnt <= 1) begin
        st_nxt.ent_ref = 1'b0;
      end
    end

    // exit: window runs one DLL exit time past CKE high
    if (cke_rise && st_r.frz) begin
      st_nxt.frz = 1'b0;
      st_nxt.ent_cnt = '0;
      st_nxt.ent_ref = 1'b0;
      st_nxt.ex_cnt = odtzq_pkg::TCNT_W'(odtzq_pkg::XPDLL_CYC);
    end else if (st_r.ex_cnt != '0) begin
      st_nxt.ex_cnt = st_r.ex_cnt - 1'b1;
    end

    // entry window keeps sync timing, exit window keeps async timing;
    // both choices sit inside the allowed either-mode band
    st_nxt.async_m = (st_nxt.frz && (st_nxt.ent_cnt == '0) &&
                      !st_nxt.ent_ref) ||
                     ((st_nxt.ex_cnt != '0) && st_r.async_m);

    // async takes the sampled pin one clock later, no additive latency
    if (st_r.async_m) begin
      st_nxt.rtt = st_r.pipe[0];
    end else begin
      st_nxt.rtt = st_r.pipe[tap];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rtt_on = st_r.rtt;
  assign async_mode = st_r.async_m;
  assign odt_trans = trans;

  ////////////////////////////////////////////////////////////////////////
  // checks

  property p_no_async_dll_on;
    @(posedge clk) disable iff (!arst_n)
      (pd_dll_fast && !st_r.frz && (st_r.ex_cnt == '0)) |=> !async_mode;
  endproperty
  a_no_async_dll_on: assert property (p_no_async_dll_on)
    else $error("asynchronous timing while the DLL stays on");

  property p_async_follow;
    @(posedge clk) disable iff (!arst_n)
      async_mode |=> (rtt_on == $past(odt, 2));
  endproperty
  a_async_follow: assert property (p_async_follow)
    else $error("asynchronous termination not one clock after ODT");

  property p_async_edge;
    @(posedge clk) disable iff (!arst_n)
      (async_mode && $past(async_mode) && $rose(odt)) |=>
        !rtt_on ##1 rtt_on;
  endproperty
  a_async_edge: assert property (p_async_edge)
    else $error("asynchronous turn-on not referenced to ODT sampled high");

  property p_sync_lat4;
    @(posedge clk) disable iff (!arst_n)
      (!async_mode && (sync_lat == 5'h04)) |=>
        (rtt_on == $past(odt, 5));
  endproperty
  a_sync_lat4: assert property (p_sync_lat4)
    else $error("synchronous termination latency wrong");

  property p_entry_window;
    @(posedge clk) disable iff (!arst_n)
      (cke_fall && !pd_dll_fast && !cmd_ref && (st_r.rfc_cnt <= 1)) |=>
        odt_trans ##1 (!odt_trans || cke_rise || $past(cke_rise));
  endproperty
  a_entry_window: assert property (p_entry_window)
    else $error("entry window length wrong");

  property p_refresh_hold;
    @(posedge clk) disable iff (!arst_n)
      (cke_fall && !pd_dll_fast && (st_r.rfc_cnt > 2) && !cke) |=>
        (odt_trans && !async_mode) [*2];
  endproperty
  a_refresh_hold: assert property (p_refresh_hold)
    else $error("entry window ended while refresh in progress");

  property p_exit_window;
    @(posedge clk) disable iff (!arst_n)
      (cke_rise && st_r.frz) |=> odt_trans && !st_r.frz;
  endproperty
  a_exit_window: assert property (p_exit_window)
    else $error("exit window did not open on CKE high");

  property p_mode_change;
    @(posedge clk) disable iff (!arst_n)
      $changed(async_mode) |-> (odt_trans || $past(odt_trans) ||
                                $past(cke_fall, 2));
  endproperty
  a_mode_change: assert property (p_mode_change)
    else $error("termination mode changed outside a transition window");

  property p_sync_lat1;
    @(posedge clk) disable iff (!arst_n)
      (!async_mode && (sync_lat == 5'h01)) |=>
        (rtt_on == $past(odt, 2));
  endproperty
  a_sync_lat1: assert property (p_sync_lat1)
    else $error("clamped synchronous termination latency wrong");

  property p_no_self_cal;
    @(posedge clk) disable iff (!arst_n)
      (!zq_busy && !cmd_zqcl && !cmd_zqcs) |=> !zq_busy;
  endproperty
  a_no_self_cal: assert property (p_no_self_cal)
    else $error("calibration started without a command");

  ////////////////////////////////////////////////////////////////////////
  // window shape and mode choice inside the windows

  property p_trans_start;
    @(posedge clk) disable iff (!arst_n)
      (cke_fall && !pd_dll_fast) |=> odt_trans;
  endproperty
  a_trans_start: assert property (p_trans_start)
    else $error("entry window did not open on CKE low");

  // exit window may overlap; only a pure entry window must stay sync
  property p_entry_sync;
    @(posedge clk) disable iff (!arst_n)
      (((st_r.ent_cnt != '0) || st_r.ent_ref) && (st_r.ex_cnt == '0)) |->
        !async_mode;
  endproperty
  a_entry_sync: assert property (p_entry_sync)
    else $error("entry window left synchronous timing");

  property p_entry_then_async;
    @(posedge clk) disable iff (!arst_n)
      (cke_fall && !pd_dll_fast && !cmd_ref && (st_r.rfc_cnt <= 1)) |->
        ##2 (async_mode || $past(cke_rise));
  endproperty
  a_entry_then_async: assert property (p_entry_then_async)
    else $error("asynchronous timing not in force after entry window");

  property p_refresh_extend;
    @(posedge clk) disable iff (!arst_n)
      (st_r.ent_ref && (st_r.rfc_cnt > 1)) |=> odt_trans;
  endproperty
  a_refresh_extend: assert property (p_refresh_extend)
    else $error("entry window closed before refresh end point");

  property p_fast_no_freeze;
    @(posedge clk) disable iff (!arst_n)
      (cke_fall && pd_dll_fast) |=> (!st_r.frz && (st_r.ent_cnt == '0));
  endproperty
  a_fast_no_freeze: assert property (p_fast_no_freeze)
    else $error("entry window opened with the DLL kept on");

  property p_exit_async_keep;
    @(posedge clk) disable iff (!arst_n)
      (cke_rise && st_r.frz && async_mode) |=> (async_mode && odt_trans);
  endproperty
  a_exit_async_keep: assert property (p_exit_async_keep)
    else $error("exit window dropped asynchronous timing");

  property p_exit_sync_after;
    @(posedge clk) disable iff (!arst_n)
      (cke_rise && st_r.frz) |-> ##2 !async_mode;
  endproperty
  a_exit_sync_after: assert property (p_exit_sync_after)
    else $error("asynchronous timing kept past the exit window");

  property p_short_idle;
    @(posedge clk) disable iff (!arst_n)
      (cke_fall && !pd_dll_fast && (st_r.ex_cnt != '0)) |=> odt_trans;
  endproperty
  a_short_idle: assert property (p_short_idle)
    else $error("overlapping exit and entry windows not merged");

endmodule : odtzq_top

// ---- hw/odtzq_pkg.sv ----
// shared constants and types for the termination and calibration block
package odtzq_pkg;

  // clock of this model
  localparam int CLK_NS = 100;

  // termination latency: ODTLon = ODTLoff = WL + AL - 2; the code clamps it to 1 when WL + AL <= 2
  localparam int PIPE_W = 32;
  localparam logic [4:0] SYNC_OFS = 5'h02;
  localparam logic [4:0] LAT_MIN = 5'h01;

  // power-down transition timing
  localparam int CPDED_NCK = 1;
  localparam int CPDED_CYC = CPDED_NCK;
  localparam int T_RFC_NS = 260;
  localparam int RFC_CYC = (T_RFC_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_XPDLL_NS = 24;
  localparam int XPDLL_RAW = (T_XPDLL_NS + CLK_NS - 1) / CLK_NS;
  localparam int XPDLL_CYC = (XPDLL_RAW < 1) ? 1 : XPDLL_RAW;
  localparam int TCNT_W = 4;
  localparam int RCNT_W = 9;

  // calibration windows, in clocks
  localparam int ZQINIT_CYC = 512;
  localparam int ZQOPER_CYC = 256;
  localparam int ZQCS_CYC = 64;
  localparam int ZCNT_W = 10;

  typedef enum logic [1:0] {
    ZQ_IDLE,
    ZQ_CAL,
    ZQ_LOAD
  } odtzq_zq_st_t;

  typedef struct packed {
    odtzq_zq_st_t st;
    logic [ZCNT_W-1:0] cnt;
    logic first_done;
  } odtzq_zq_t;

  typedef struct packed {
    logic [PIPE_W-1:0] pipe;
    logic cke_q;
    logic frz;
    logic async_m;
    logic ent_ref;
    logic rtt;
    logic [TCNT_W-1:0] ent_cnt;
    logic [TCNT_W-1:0] ex_cnt;
    logic [RCNT_W-1:0] rfc_cnt;
  } odtzq_st_t;

endpackage : odtzq_pkg

// ---- hw/odtzq_zq_if.sv ----
// calibration command and status between the top and the engine
`timescale 1ns/1ps
interface odtzq_zq_if;
  logic start_long;
  logic start_short;
  logic busy;
  logic cur_en;
  logic load;

  modport eng (
    input start_long,
    input start_short,
    output busy,
    output cur_en,
    output load
  );

  modport ctl (
    output start_long,
    output start_short,
    input busy,
    input cur_en,
    input load
  );
endinterface : odtzq_zq_if

// ---- hw/odtzq_zq_engine.sv ----
// calibration engine: long and short calibration windows
`timescale 1ns/1ps
module odtzq_zq_engine (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // commands and status
  odtzq_zq_if.eng zq
);

  odtzq_pkg::odtzq_zq_t st_r;
  odtzq_pkg::odtzq_zq_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    unique case (st_r.st)
      odtzq_pkg::ZQ_IDLE: begin
        // a new command while busy is dropped; channel must stay quiet
        if (zq.start_long) begin
          st_nxt.st = odtzq_pkg::ZQ_CAL;
          st_nxt.first_done = 1'b1;
          st_nxt.cnt = st_r.first_done ?
            odtzq_pkg::ZCNT_W'(odtzq_pkg::ZQOPER_CYC - 2) :
            odtzq_pkg::ZCNT_W'(odtzq_pkg::ZQINIT_CYC - 2);
        end else if (zq.start_short) begin
          st_nxt.st = odtzq_pkg::ZQ_CAL;
          st_nxt.cnt = odtzq_pkg::ZCNT_W'(odtzq_pkg::ZQCS_CYC - 2);
        end
      end
      odtzq_pkg::ZQ_CAL: begin
        if (st_r.cnt == '0) begin
          st_nxt.st = odtzq_pkg::ZQ_LOAD;
        end else begin
          st_nxt.cnt = st_r.cnt - 1'b1;
        end
      end
      odtzq_pkg::ZQ_LOAD: begin
        st_nxt.st = odtzq_pkg::ZQ_IDLE;
      end
      default: begin
        st_nxt.st = odtzq_pkg::ZQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign zq.busy = (st_r.st != odtzq_pkg::ZQ_IDLE);
  // current path only during the measuring phase
  assign zq.cur_en = (st_r.st == odtzq_pkg::ZQ_CAL);
  assign zq.load = (st_r.st == odtzq_pkg::ZQ_LOAD);

  ////////////////////////////////////////////////////////////////////////
  // helper: measure each busy window against its expected length
  logic [odtzq_pkg::ZCNT_W-1:0] h_len;
  logic [odtzq_pkg::ZCNT_W-1:0] h_exp;
  logic h_first;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      h_len <= '0;
      h_exp <= '0;
      h_first <= 1'b0;
    end else if (!zq.busy && zq.start_long) begin
      h_len <= 10'h001;
      h_first <= 1'b1;
      h_exp <= h_first ? odtzq_pkg::ZCNT_W'(odtzq_pkg::ZQOPER_CYC) :
                         odtzq_pkg::ZCNT_W'(odtzq_pkg::ZQINIT_CYC);
    end else if (!zq.busy && zq.start_short) begin
      h_len <= 10'h001;
      h_exp <= odtzq_pkg::ZCNT_W'(odtzq_pkg::ZQCS_CYC);
    end else if (zq.busy) begin
      h_len <= h_len + 1'b1;
    end
  end

  property p_zq_len;
    @(posedge clk) disable iff (!arst_n)
      $fell(zq.busy) |-> ($past(h_len) == h_exp);
  endproperty
  a_zq_len: assert property (p_zq_len)
    else $error("calibration window has the wrong length");

  property p_zq_short;
    @(posedge clk) disable iff (!arst_n)
      (!zq.busy && !zq.start_long && zq.start_short) |=>
        zq.cur_en [*8] ##56 zq.load ##1 !zq.busy;
  endproperty
  a_zq_short: assert property (p_zq_short)
    else $error("short calibration did not finish in its window");

  property p_zq_cur_off;
    @(posedge clk) disable iff (!arst_n)
      zq.load |=> !zq.cur_en throughout (!zq.busy [*1]);
  endproperty
  a_zq_cur_off: assert property (p_zq_cur_off)
    else $error("calibration current left on after completion");

  property p_zq_load_after_cal;
    @(posedge clk) disable iff (!arst_n)
      zq.load |-> ($past(zq.cur_en) && !zq.cur_en);
  endproperty
  a_zq_load_after_cal: assert property (p_zq_load_after_cal)
    else $error("values loaded without a preceding calibration");

endmodule : odtzq_zq_engine

// ---- tb/odtzq_ctl_model.sv ----
// controller model: calibration commands and channel guarding
`timescale 1ns/1ps
module odtzq_ctl_model (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // requests from the bench
  input wire logic req_long,
  input wire logic req_short,
  input wire logic force_cmd,
  input wire logic cke_req,
  input wire logic odt_req,
  // device side
  input wire logic zq_busy,
  output logic cmd_zqcl,
  output logic cmd_zqcs,
  output logic cke,
  output logic odt
);
  logic ok;
  // no bank is ever opened and no self-refresh is used, so only busy gates, unless force_cmd overrides it
  assign ok = !zq_busy || force_cmd;
  assign cmd_zqcl = req_long && ok;
  assign cmd_zqcs = req_short && ok;
  assign cke = zq_busy ? 1'h1 : cke_req;
  assign odt = zq_busy ? 1'h0 : odt_req;
endmodule : odtzq_ctl_model

// ---- tb/test_odtzq_top.sv ----
// self-checking bench for the termination and calibration block
`timescale 1ns/1ps
module test_odtzq_top;
  logic clk = 1'h0;
  logic arst_n = 1'h0;
  logic cke_req = 1'h1;
  logic odt_req = 1'h0;
  logic cmd_ref = 1'h0;
  logic req_long = 1'h0;
  logic req_short = 1'h0;
  logic force_cmd = 1'h0;
  logic pd_dll_fast = 1'h0;
  logic [3:0] wl = 4'h5;
  logic [3:0] al = 4'h0;
  logic [3:0] w, a;
  logic cke, odt, cmd_zqcl, cmd_zqcs;
  logic rtt_on, async_mode, odt_trans, zq_busy, zq_cur_en, zq_load;
  logic [31:0] seed = 32'h0000004D;
  int bad_count = 0;
  int num_checks = 0;

  always #50 clk = ~clk;

  odtzq_ctl_model i_ctl (.clk(clk), .arst_n(arst_n), .req_long(req_long),
    .req_short(req_short), .force_cmd(force_cmd), .cke_req(cke_req),
    .odt_req(odt_req), .zq_busy(zq_busy), .cmd_zqcl(cmd_zqcl),
    .cmd_zqcs(cmd_zqcs), .cke(cke), .odt(odt));
  odtzq_top i_dut (.clk(clk), .arst_n(arst_n), .cke(cke), .odt(odt),
    .cmd_ref(cmd_ref), .cmd_zqcl(cmd_zqcl), .cmd_zqcs(cmd_zqcs),
    .pd_dll_fast(pd_dll_fast), .wl(wl), .al(al), .rtt_on(rtt_on),
    .async_mode(async_mode), .odt_trans(odt_trans), .zq_busy(zq_busy),
    .zq_cur_en(zq_cur_en), .zq_load(zq_load));

  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  function automatic int exp_lat(input logic [3:0] wv, input logic [3:0] av);
    int l;
    l = int'(wv) + int'(av) - 2;
    return (l < 1) ? 1 : l;
  endfunction : exp_lat

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  task automatic tdone(input string nm);
    $display("test %s done", nm);
  endtask : tdone

  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  // odt step, then rtt must hold off for l edges and follow on the next
  task automatic lat(input logic v, input int l);
    @(posedge clk) odt_req <= v;
    repeat (l) @(posedge clk);
    @(negedge clk);
    chk("rtt_early", !v, rtt_on);
    @(posedge clk);
    @(negedge clk);
    chk("rtt_on", v, rtt_on);
  endtask : lat

  // entry window keeps sync timing, exit window keeps async timing
  task automatic pd(input logic v, input logic fast);
    @(posedge clk) cke_req <= v;
    @(posedge clk);
    @(negedge clk);
    chk("odt_trans", !fast, odt_trans);
    chk("async_win", !fast && v, async_mode);
    @(posedge clk);
    @(negedge clk);
    chk("odt_trans_end", 1'h0, odt_trans);
    chk("async_mode", !fast && !v, async_mode);
  endtask : pd

  // one calibration; a refused short command is forced in mid-window
  task automatic zq(input logic lng, input logic intr, input int n);
    int b, c, d;
    b = 0;
    c = 0;
    d = 0;
    @(posedge clk) req_long <= lng;
    req_short <= !lng;
    for (int i = 0; i < 1000; i++) begin
      @(posedge clk);
      req_long <= 1'h0;
      req_short <= intr && (i == 10);
      force_cmd <= intr && (i == 10);
      @(negedge clk);
      if (zq_busy !== 1'h1) break;
      b++;
      c += zq_cur_en;
      d += zq_load;
    end
    chk("zq_busy_len", n, b);
    chk("zq_cur_en_len", n - 1, c);
    chk("zq_load_cnt", 1, d);
    chk("zq_cur_off", 1'h0, zq_cur_en);
  endtask : zq

  ////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1'h1;
    @(negedge clk);
    chk("rst_out", 6'h00, {rtt_on, async_mode, odt_trans, zq_busy,
        zq_cur_en, zq_load});
    for (int t = 0; t < 12; t++) begin
      seed = xs(seed);
      w = (t < 2) ? 4'h1 + 4'(5 * t) : 4'h5 + 4'(seed[2:0]);
      a = (t < 2) ? 4'h0 : 4'(seed[5:3]);
      @(posedge clk) wl <= w;
      al <= a;
      // the pipeline must hold one odt level after the latency moves
      repeat (33) @(posedge clk);
      lat(1'h1, exp_lat(w, a));
      lat(1'h0, exp_lat(w, a));
    end
    tdone("latency");
    pd(1'h0, 1'h0);
    lat(1'h1, 1);
    lat(1'h0, 1);
    pd(1'h1, 1'h0);
    repeat (33) @(posedge clk);
    lat(1'h1, exp_lat(w, a));
    lat(1'h0, exp_lat(w, a));
    tdone("power_down");
    @(posedge clk) cmd_ref <= 1'h1;
    @(posedge clk) cmd_ref <= 1'h0;
    cke_req <= 1'h0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("ref_window", 1'h1, odt_trans);
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("ref_end", 2'h1, {odt_trans, async_mode});
    pd(1'h1, 1'h0);
    // short low then short high: entry and exit windows merge
    @(posedge clk) cke_req <= 1'h0;
    @(posedge clk) cke_req <= 1'h1;
    @(posedge clk) cke_req <= 1'h0;
    @(negedge clk);
    chk("short_pd", 2'h2, {odt_trans, async_mode});
    @(negedge clk);
    chk("short_idle", 2'h2, {odt_trans, async_mode});
    @(negedge clk);
    chk("merged_end", 2'h1, {odt_trans, async_mode});
    pd(1'h1, 1'h0);
    @(posedge clk) pd_dll_fast <= 1'h1;
    pd(1'h0, 1'h1);
    pd(1'h1, 1'h1);
    chk("no_self_cal", 1'h0, zq_busy);
    tdone("refresh_fast");
    zq(1'h1, 1'h0, odtzq_pkg::ZQINIT_CYC);
    zq(1'h1, 1'h1, odtzq_pkg::ZQOPER_CYC);
    zq(1'h0, 1'h0, odtzq_pkg::ZQCS_CYC);
    @(posedge clk) arst_n <= 1'h0;
    repeat (2) @(posedge clk);
    arst_n <= 1'h1;
    zq(1'h1, 1'h0, odtzq_pkg::ZQINIT_CYC);
    tdone("calibration");
    final_report();
  end

  initial begin
    #(20000 * odtzq_pkg::CLK_NS);
    bad_count++;
    $display("watchdog expired");
    final_report();
  end
endmodule : test_odtzq_top
